// >>> common/cache_mode_pkg.sv
/*
  Constants for the cache-mode policy block: register indexes, field
  positions, reset values and mode codes.
  Assumes a single 100 MHz clock domain and a plain register port.
*/
`default_nettype none
package cache_mode_pkg;
  // register indexes (word addresses on the register port)
  localparam logic [3:0] REG_PRIMARY_CTRL = 4'h0;
  localparam logic [3:0] REG_PAGE_DIR     = 4'h1;
  localparam logic [3:0] REG_FOURTH_CTRL  = 4'h2;
  localparam logic [3:0] REG_MISC_FEATURE = 4'h3;
  localparam logic [3:0] REG_STATUS       = 4'h4;
  localparam logic [3:0] REG_CONFIG       = 4'h5;
  // primary control fields
  localparam int CACHE_OFF_POS     = 30;
  localparam int WT_FORCE_POS      = 29;
  localparam int PAGING_ON_POS     = 31;
  // page directory base fields
  localparam int PD_WT_POS         = 3;
  localparam int PD_UNCACHED_POS   = 4;
  // fourth control field
  localparam int GLOBAL_PAGE_POS   = 7;
  // misc feature field
  localparam int L3_OFF_POS        = 6;
  // config fields: family select and dual-processor strap copy
  localparam int FAMILY_LO_POS     = 0;
  localparam int DUAL_PROC_POS     = 2;
  // status fields
  localparam int STAT_MODE_LO      = 0;
  localparam int STAT_FAULT_POS    = 4;
  localparam int STAT_SNOOP_L1_POS = 5;
  localparam int STAT_PARITY_POS   = 6;
  // family codes
  localparam logic [1:0] FAMILY_NEW    = 2'h0;
  localparam logic [1:0] FAMILY_OLD    = 2'h1;
  localparam logic [1:0] FAMILY_LOWPWR = 2'h2;
  localparam logic [1:0] FAMILY_RESET  = FAMILY_NEW;
  localparam logic [15:0] FAULT_CODE  = 16'h0000;
  // cache modes, one-hot
  typedef enum logic [3:0] {
    MODE_NORMAL   = 4'b0001,
    MODE_NO_FILL  = 4'b0010,
    MODE_NON_COH  = 4'b0100,
    MODE_DISABLED = 4'b1000
  } cache_mode_e;
endpackage
`default_nettype wire

// >>> rtl/cache_mode_policy_control.sv
/*
  Cache operating-mode control: decodes the two global control bits into a
  mode, rejects the invalid combination, and derives per-access policy from
  page and directory attributes. Assumes one clock; snoop, parity and access
  requests are pulses from logic on the same clock, the strap is a pin.
*/
// Our own choices: the placing of the registers and strobed register access.
// Notes on behaviour
// R1 - cache-off 0 with write-through-force 1 is rejected with fault, code zero
// R2 - no-fill: read hits served, read misses never allocate
// R3 - no-fill: write hits update; shared and miss writes go to memory
// R4 - no-fill: shared write hit may go exclusive with read-invalidate cycle
// R5 - no-fill: coherent, snoops accepted everywhere, invalidation allowed
// R6 - while caching is off strict ordering only when ranges off or all uncached
// R7 - newer families reset to no-fill, older with both bits set
// R8 - both bits set: not coherent, no read replace, write misses to memory
// R9 - both bits set: write hits update, exclusive to modified, shared stays
// R10 - both bits set: snoops never invalidate; L1 refuses snoops, lower accept
// R11 - newer families: both bits select no-fill, force flag ignored when off
// R12 - low-power families: cache-off disables caching entirely
// R13 - force flag at bit 29; both clear means write-back except where page bits or the write-back pin select write-through
// R14 - older parts, L1 off: snoops accepted dual-processor, inhibited otherwise
// R15 - inhibited snoops skip parity; accepted snoops flag corrupt address
// R16 - page uncached bit works only with paging on and cache-off clear
// R17 - page write-through bit works only with paging on and force clear
// R18 - directory bits govern only the directory, with paging and caching on
// R19 - sticky pages are global only when global-page enable is set
// R20 - misc bit 6 disables level three independently
// R21 - older parts take external cacheable and write-back pins, drive page pins
// R22 - cache-off at bit 30; snoops still answered while set
// R23 - normal: read misses may replace, write misses fill
// R24 - mode registered on control write, applies to later accesses
// R25 - software flushes caches after setting cache-off
`timescale 1ns/10ps
`default_nettype none
module cache_mode_policy_control
  import cache_mode_pkg::*;
(
  // clock and reset
  input  wire  logic        clk,
  input  wire  logic        resetn,
  // register port
  input  wire  logic [3:0]  reg_addr,
  input  wire  logic [31:0] reg_wdata,
  input  wire  logic        reg_write,
  input  wire  logic        reg_read,
  output var   logic [31:0] reg_rdata,
  // straps and external pins
  input  wire  logic        dual_processor_system,
  input  wire  logic        cacheable_enable_pin_n,
  input  wire  logic        writeback_select_pin,
  // access request
  input  wire  logic        acc_valid,
  input  wire  logic        acc_write,
  input  wire  logic        acc_hit,
  input  wire  logic        acc_shared,
  input  wire  logic        acc_dir,
  input  wire  logic        acc_sticky,
  input  wire  logic        page_uncached_bit,
  input  wire  logic        page_write_through_bit,
  input  wire  logic        ranges_enabled,
  // snoop request
  input  wire  logic        snoop_valid,
  input  wire  logic        snoop_parity_ok,
  input  wire  logic        invalidate_op,
  // access decision
  output var   logic        dec_valid,
  output var   logic        dec_cacheable,
  output var   logic        dec_write_through,
  output var   logic        dec_allocate,
  output var   logic        dec_to_memory,
  output var   logic        dec_go_exclusive,
  output var   logic        dec_go_modified,
  output var   logic        dec_read_inval,
  output var   logic        dec_strict_order,
  output var   logic        dec_global,
  output var   logic        dec_l3_enable,
  output var   logic        page_uncached_pin,
  output var   logic        page_write_through_pin,
  // snoop decision and faults
  output var   logic        snoop_l1_accept,
  output var   logic        snoop_low_accept,
  output var   logic        snoop_invalidate,
  output var   logic        addr_parity_error_pin_n,
  output var   logic        protection_fault,
  output var   logic [15:0] fault_code,
  // current mode
  output var   logic [3:0]  cache_mode
);

////////////////////////////////////////////////////////////////////////////////
  logic        rst_meta_n, rst_n;
  logic        dp_meta, dp_sync, ken_meta, ken_sync, wbs_meta, wbs_sync;
  logic [1:0]  family;
  logic        dual_strap, cache_off, wt_force, paging_on;
  logic        pd_uncached, pd_wt, global_page_en, l3_off;
  logic        fault_sticky, parity_sticky;
  cache_mode_e mode, next_mode;
  logic        wr_primary, bad_combo, new_off, new_force;
  logic        l1_snoop_ok, uncached_now, wt_now;

////////////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end
    else
    begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dp_meta  <= 1'b0;
      dp_sync  <= 1'b0;
      ken_meta <= 1'b1;
      ken_sync <= 1'b1;
      wbs_meta <= 1'b0;
      wbs_sync <= 1'b0;
    end
    else
    begin
      dp_meta  <= dual_processor_system;
      dp_sync  <= dp_meta;
      ken_meta <= cacheable_enable_pin_n;
      ken_sync <= ken_meta;
      wbs_meta <= writeback_select_pin;
      wbs_sync <= wbs_meta;
    end
  end

////////////////////////////////////////////////////////////////////////////////
  // mode decode shared by config and primary-control write paths
  function automatic cache_mode_e decode_mode(input logic [1:0] fam,
                                              input logic off, input logic frc);
    if (!off)
      decode_mode = MODE_NORMAL;                            // R13 R23
    else if (fam == FAMILY_LOWPWR)
      decode_mode = MODE_DISABLED;                          // R12
    else if (fam == FAMILY_NEW || !frc)
      decode_mode = MODE_NO_FILL;                           // R11
    else
      decode_mode = MODE_NON_COH;
  endfunction

  assign wr_primary = reg_write && (reg_addr == REG_PRIMARY_CTRL);
  assign new_off    = reg_wdata[CACHE_OFF_POS];             // R22
  assign new_force  = reg_wdata[WT_FORCE_POS];              // R13
  assign bad_combo  = wr_primary && !new_off && new_force;  // R1

  always_comb
  begin
    next_mode = mode;
    if (wr_primary && !bad_combo)
      next_mode = decode_mode(family, new_off, new_force);  // R24
  end

////////////////////////////////////////////////////////////////////////////////
  // control registers; family set by config write, strap copied every cycle after release
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      family         <= FAMILY_RESET;
      dual_strap     <= 1'b0;
      cache_off      <= 1'b1;                               // R7
      wt_force       <= 1'b0;
      paging_on      <= 1'b0;
      pd_uncached    <= 1'b0;
      pd_wt          <= 1'b0;
      global_page_en <= 1'b0;
      l3_off         <= 1'b0;
      mode           <= MODE_NO_FILL;
    end
    else
    begin
      dual_strap <= dp_sync;
      if (reg_write && reg_addr == REG_CONFIG)
      begin
        family   <= reg_wdata[FAMILY_LO_POS +: 2];
        // older families come up with both bits set
        wt_force <= (reg_wdata[FAMILY_LO_POS +: 2] == FAMILY_OLD);   // R7
        mode     <= decode_mode(reg_wdata[FAMILY_LO_POS +: 2], 1'b1,
                      reg_wdata[FAMILY_LO_POS +: 2] == FAMILY_OLD);  // R7
        cache_off <= 1'b1;
      end
      else
      begin
        mode <= next_mode;
        if (wr_primary && !bad_combo)                       // R1
        begin
          cache_off <= new_off;
          wt_force  <= new_force;
          paging_on <= reg_wdata[PAGING_ON_POS];
        end
      end
      if (reg_write && reg_addr == REG_PAGE_DIR)
      begin
        pd_uncached <= reg_wdata[PD_UNCACHED_POS];
        pd_wt       <= reg_wdata[PD_WT_POS];
      end
      if (reg_write && reg_addr == REG_FOURTH_CTRL)
        global_page_en <= reg_wdata[GLOBAL_PAGE_POS];
      if (reg_write && reg_addr == REG_MISC_FEATURE)
        l3_off <= reg_wdata[L3_OFF_POS];                    // R20
    end
  end

////////////////////////////////////////////////////////////////////////////////
  // fault: pulse plus sticky status, set wins over clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      protection_fault <= 1'b0;
      fault_code       <= 16'h0000;
      fault_sticky     <= 1'b0;
    end
    else
    begin
      protection_fault <= bad_combo;                        // R1
      fault_code       <= FAULT_CODE;                       // R1
      if (bad_combo)
        fault_sticky <= 1'b1;
      else if (reg_write && reg_addr == REG_STATUS && reg_wdata[STAT_FAULT_POS])
        fault_sticky <= 1'b0;
    end
  end

////////////////////////////////////////////////////////////////////////////////
  // register read, data valid in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 32'h0000_0000;
    else if (reg_read)
    begin
      reg_rdata <= 32'h0000_0000;
      unique case (reg_addr)
        REG_PRIMARY_CTRL:
        begin
          reg_rdata[PAGING_ON_POS] <= paging_on;
          reg_rdata[CACHE_OFF_POS] <= cache_off;
          reg_rdata[WT_FORCE_POS]  <= wt_force;
        end
        REG_PAGE_DIR:
        begin
          reg_rdata[PD_UNCACHED_POS] <= pd_uncached;
          reg_rdata[PD_WT_POS]       <= pd_wt;
        end
        REG_FOURTH_CTRL:  reg_rdata[GLOBAL_PAGE_POS] <= global_page_en;
        REG_MISC_FEATURE: reg_rdata[L3_OFF_POS] <= l3_off;
        REG_STATUS:
        begin
          reg_rdata[STAT_MODE_LO +: 4]  <= mode;
          reg_rdata[STAT_FAULT_POS]     <= fault_sticky;
          reg_rdata[STAT_SNOOP_L1_POS]  <= l1_snoop_ok;
          reg_rdata[STAT_PARITY_POS]    <= parity_sticky;
        end
        REG_CONFIG:
        begin
          reg_rdata[FAMILY_LO_POS +: 2] <= family;
          reg_rdata[DUAL_PROC_POS]      <= dual_strap;
        end
        default:          reg_rdata <= 32'h0000_0000;
      endcase
    end
    else
      reg_rdata <= 32'h0000_0000;
  end

////////////////////////////////////////////////////////////////////////////////
  // per-access policy
  // older parts: L1 off in non-coherent mode snoops only in dual-processor
  assign l1_snoop_ok = (mode != MODE_NON_COH) ||
                       (family == FAMILY_OLD && dual_strap);             // R10 R14
  // page and directory bits only count with paging on; uncached needs cache-off clear, write-through needs force clear (directory: both)
  assign uncached_now = paging_on && !cache_off &&
                        (acc_dir ? pd_uncached : page_uncached_bit);     // R16 R18
  assign wt_now = paging_on && !wt_force &&
                  (acc_dir ? (pd_wt && !cache_off) : page_write_through_bit); // R17 R18

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dec_valid         <= 1'b0;
      dec_cacheable     <= 1'b0;
      dec_write_through <= 1'b0;
      dec_allocate      <= 1'b0;
      dec_to_memory     <= 1'b0;
      dec_go_exclusive  <= 1'b0;
      dec_go_modified   <= 1'b0;
      dec_read_inval    <= 1'b0;
      dec_strict_order  <= 1'b0;
      dec_global        <= 1'b0;
      dec_l3_enable     <= 1'b0;
      page_uncached_pin      <= 1'b0;
      page_write_through_pin <= 1'b0;
    end
    else
    begin
      dec_valid <= acc_valid;
      // older parts: external pins also gate cacheability and write policy
      dec_cacheable <= acc_valid && mode != MODE_DISABLED && !uncached_now &&
                       !(family == FAMILY_OLD && ken_sync);              // R12 R21
      dec_write_through <= acc_valid && (wt_now ||
                           (family == FAMILY_OLD && !wbs_sync));         // R17 R21
      dec_allocate <= acc_valid && !acc_hit && mode == MODE_NORMAL &&
                      !uncached_now;                                     // R2 R3 R8 R23
      dec_to_memory <= acc_valid && acc_write &&
                       (!acc_hit || acc_shared || mode == MODE_DISABLED ||
                        wt_now);                                         // R3 R8
      dec_go_exclusive <= acc_valid && acc_write && acc_hit && acc_shared &&
                          mode == MODE_NO_FILL && ranges_enabled;        // R4
      dec_read_inval <= acc_valid && acc_write && acc_hit && acc_shared &&
                        mode == MODE_NO_FILL && ranges_enabled;          // R4
      dec_go_modified <= acc_valid && acc_write && acc_hit && !acc_shared &&
                         mode != MODE_DISABLED;                          // R9
      dec_strict_order <= acc_valid && cache_off &&
                          (!ranges_enabled || uncached_now ||
                           mode == MODE_DISABLED);                       // R6
      dec_global    <= acc_valid && acc_sticky && global_page_en;       // R19
      dec_l3_enable <= acc_valid && !l3_off && mode != MODE_DISABLED;   // R20
      // page pins let an external cache follow the page policy
      page_uncached_pin      <= acc_valid && uncached_now;   // R21
      page_write_through_pin <= acc_valid && wt_now;         // R21
    end
  end

////////////////////////////////////////////////////////////////////////////////
  // snoop handling; snoops answered even with cache-off set
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      snoop_l1_accept         <= 1'b0;
      snoop_low_accept        <= 1'b0;
      snoop_invalidate        <= 1'b0;
      addr_parity_error_pin_n <= 1'b1;
      parity_sticky           <= 1'b0;
      cache_mode              <= MODE_NO_FILL;
    end
    else
    begin
      cache_mode       <= mode;
      snoop_l1_accept  <= snoop_valid && l1_snoop_ok;              // R5 R10 R22
      snoop_low_accept <= snoop_valid && mode != MODE_DISABLED;   // R5 R10
      snoop_invalidate <= invalidate_op ||
                          (snoop_valid && mode != MODE_NON_COH);   // R5 R10
      addr_parity_error_pin_n <= !(snoop_valid && l1_snoop_ok &&
                                   !snoop_parity_ok);              // R15
      if (snoop_valid && l1_snoop_ok && !snoop_parity_ok)
        parity_sticky <= 1'b1;
      else if (reg_write && reg_addr == REG_STATUS && reg_wdata[STAT_PARITY_POS])
        parity_sticky <= 1'b0;
    end
  end

////////////////////////////////////////////////////////////////////////////////
  AST_FAULT_ON_BAD: assert property (@(posedge clk) disable iff (!rst_n) // R1
    bad_combo |=> protection_fault && fault_code == 16'h0000 && $stable(cache_off))
    else $error("invalid combination not faulted");
  AST_NOFILL_NO_ALLOC: assert property (@(posedge clk) disable iff (!rst_n) // R2
    (acc_valid && !acc_hit && mode == MODE_NO_FILL) |=> !dec_allocate)
    else $error("no-fill miss allocated");
  AST_NOFILL_MISS_MEM: assert property (@(posedge clk) disable iff (!rst_n) // R3
    (acc_valid && acc_write && !acc_hit) |=> dec_to_memory)
    else $error("write miss kept from memory");
  AST_RFI_PAIR: assert property (@(posedge clk) disable iff (!rst_n) // R4
    dec_go_exclusive |-> dec_read_inval && dec_to_memory && $past(mode) == MODE_NO_FILL)
    else $error("exclusive upgrade without read-invalidate");
  AST_NONCOH_SNOOP: assert property (@(posedge clk) disable iff (!rst_n) // R10
    (snoop_valid && !invalidate_op && mode == MODE_NON_COH) |=> !snoop_invalidate)
    else $error("snoop invalidated in non-coherent mode");
  AST_PARITY_INHIBIT: assert property (@(posedge clk) disable iff (!rst_n) // R15
    (snoop_valid && !l1_snoop_ok) |=> addr_parity_error_pin_n)
    else $error("parity flagged with snoops inhibited");
  AST_GLOBAL_GATE: assert property (@(posedge clk) disable iff (!rst_n) // R19
    dec_global |-> $past(global_page_en))
    else $error("global page without enable");
  AST_MODE_APPLY: assert property (@(posedge clk) disable iff (!rst_n) // R24
    (wr_primary && !bad_combo && !new_off) |=> mode == MODE_NORMAL ##1
    cache_mode == MODE_NORMAL)
    else $error("mode not applied after write");
  COV_FAULT:  cover property (@(posedge clk) disable iff (!rst_n) protection_fault);
  COV_NONCOH: cover property (@(posedge clk) disable iff (!rst_n) mode == MODE_NON_COH);
  COV_RFI:    cover property (@(posedge clk) disable iff (!rst_n) dec_read_inval);
endmodule
`default_nettype wire

// >>> tb/snoop_agent.sv
/*
  Far-side model: snoop agent plus the external caching pins of the board.
  Assumes the bench pulses go for one cycle, set just after a rising edge.
*/
`timescale 1ns/10ps
`default_nettype none
module snoop_agent
(
  // clock
  input  wire logic clk,
  // bench command
  input  wire logic go,
  input  wire logic bad,
  input  wire logic [2:0] board,
  // toward the block
  output var  logic snoop_valid,
  output var  logic snoop_parity_ok,
  output var  logic dual_processor_system,
  output var  logic cacheable_enable_pin_n,
  output var  logic writeback_select_pin
);
  // board pins {write-back, cacheable_n, dual} come from the bench
  assign dual_processor_system  = board[0];
  assign cacheable_enable_pin_n = board[1];
  assign writeback_select_pin   = board[2];
  initial snoop_valid = 1'b0;
  initial snoop_parity_ok = 1'b0;
  // parity toggles between snoops so a stale value never holds steady
  always @(posedge clk)
  begin
    snoop_valid     <= go;
    snoop_parity_ok <= go ? !bad : !snoop_parity_ok;
  end
endmodule
`default_nettype wire

// >>> tb/tb.sv
/*
  Self-checking bench for the cache-mode policy block.
  Assumes the package constants and the snoop_agent model beside it.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
  import cache_mode_pkg::*;
  logic        clk, resetn, reg_write, reg_read, acc_valid, go, bad, inval, dir;
  logic [2:0]  board;
  logic [3:0]  reg_addr, mode;
  logic [31:0] reg_wdata, reg_rdata;
  logic [6:0]  af;
  logic        sv, spok, dps, ken_n, wbs, dv, dc, dwt, dal, dmem, dex, dmod, dri;
  logic        dso, dgl, dl3, pup, pwp, sl1, slo, sinv, perr_n, pfault;
  logic [15:0] fcode;
  int          mismatches = 0;
  int          tests_run = 0;
  int          cycles = 0;
  //////////////////////////////////////////////////////////////////////////////
  // af packs {sticky, ranges, page wt, page uncached, shared, hit, write}
  cache_mode_policy_control i_dut
  (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .dual_processor_system(dps), .cacheable_enable_pin_n(ken_n),
    .writeback_select_pin(wbs), .acc_valid(acc_valid), .acc_write(af[0]),
    .acc_hit(af[1]), .acc_shared(af[2]), .acc_dir(dir), .acc_sticky(af[6]),
    .page_uncached_bit(af[3]), .page_write_through_bit(af[4]),
    .ranges_enabled(af[5]), .snoop_valid(sv), .snoop_parity_ok(spok),
    .invalidate_op(inval), .dec_valid(dv), .dec_cacheable(dc),
    .dec_write_through(dwt), .dec_allocate(dal), .dec_to_memory(dmem),
    .dec_go_exclusive(dex), .dec_go_modified(dmod), .dec_read_inval(dri),
    .dec_strict_order(dso), .dec_global(dgl), .dec_l3_enable(dl3),
    .page_uncached_pin(pup), .page_write_through_pin(pwp),
    .snoop_l1_accept(sl1), .snoop_low_accept(slo), .snoop_invalidate(sinv),
    .addr_parity_error_pin_n(perr_n), .protection_fault(pfault),
    .fault_code(fcode), .cache_mode(mode)
  );
  snoop_agent i_agent
  (
    .clk(clk), .go(go), .bad(bad), .board(board), .snoop_valid(sv), .snoop_parity_ok(spok),
    .dual_processor_system(dps), .cacheable_enable_pin_n(ken_n),
    .writeback_select_pin(wbs)
  );
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // a hang costs one mismatch and still reaches the report
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      wrap_up();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    #1;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    chk("rdata", e, reg_rdata & m);
  endtask
  // mode shows on cache_mode one cycle after the internal update
  task automatic md(input logic [3:0] a, input logic [31:0] d, input logic [3:0] m);
    wr(a, d);
    @(posedge clk);
    #1;
    chk("cache_mode", m, mode);
  endtask
  task automatic acc(input logic [6:0] f);
    @(posedge clk);
    af        <= f;
    acc_valid <= 1'b1;
    @(posedge clk);
    acc_valid <= 1'b0;
    #1;
    chk("dec_valid", 1, dv);
  endtask
  // agent adds one cycle before the snoop reaches the block
  task automatic snoop(input logic b);
    @(posedge clk);
    go  <= 1'b1;
    bad <= b;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  // explicit invalidate pulse; its answer stands in the cycle after
  task automatic flush;
    @(posedge clk);
    inval <= 1'b1;
    @(posedge clk);
    inval <= 1'b0;
    #1;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    resetn    = 1'b0;
    reg_write = 1'b0;
    reg_read  = 1'b0;
    reg_addr  = 4'h0;
    reg_wdata = 32'h0;
    acc_valid = 1'b0;
    af        = 7'h00;
    dir       = 1'b0;
    board     = 3'b100;
    go        = 1'b0;
    bad       = 1'b0;
    inval     = 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("cache_mode", 4'h2, mode);
    chk("parity_pin", 1, perr_n);
    rdchk(REG_PRIMARY_CTRL, 32'h6000_0000, 32'h4000_0000);
    wr(REG_PRIMARY_CTRL, 32'h2000_0000);
    chk("fault", 1, pfault);
    chk("fault_code", 16'h0000, fcode);
    @(posedge clk);
    #1;
    chk("cache_mode", 4'h2, mode);
    rdchk(REG_STATUS, 32'h10, 32'h10);
    $display("test reset and fault done");
    md(REG_PRIMARY_CTRL, 32'h8000_0000, 4'h1);
    rdchk(REG_PRIMARY_CTRL, 32'h6000_0000, 32'h0);
    acc(7'h01);
    chk("allocate", 1, dal);
    chk("to_memory", 1, dmem);
    acc(7'h0A);
    chk("cacheable", 0, dc);
    chk("uncached_pin", 1, pup);
    acc(7'h12);
    chk("write_through", 1, dwt);
    chk("cacheable", 1, dc);
    chk("wt_pin", 1, pwp);
    wr(REG_MISC_FEATURE, 32'h40);
    acc(7'h02);
    chk("l3_enable", 0, dl3);
    chk("write_through", 0, dwt);
    wr(REG_MISC_FEATURE, 32'h0);
    acc(7'h02);
    chk("l3_enable", 1, dl3);
    wr(REG_FOURTH_CTRL, 32'h80);
    acc(7'h42);
    chk("global", 1, dgl);
    wr(REG_FOURTH_CTRL, 32'h0);
    acc(7'h42);
    chk("global", 0, dgl);
    wr(REG_PAGE_DIR, 32'h10);
    @(posedge clk) dir <= 1'b1;
    acc(7'h02);
    chk("dir_cacheable", 0, dc);
    @(posedge clk) dir <= 1'b0;
    acc(7'h02);
    chk("cacheable", 1, dc);
    $display("test normal mode done");
    md(REG_PRIMARY_CTRL, 32'hC000_0000, 4'h2);
    flush();
    chk("snoop_inval", 1, sinv);
    acc(7'h00);
    chk("allocate", 0, dal);
    chk("strict", 1, dso);
    acc(7'h21);
    chk("allocate", 0, dal);
    chk("to_memory", 1, dmem);
    chk("strict", 0, dso);
    acc(7'h27);
    chk("exclusive", 1, dex);
    chk("read_inval", 1, dri);
    chk("to_memory", 1, dmem);
    snoop(1'b1);
    chk("l1_snoop", 1, sl1);
    chk("parity_pin", 0, perr_n);
    md(REG_PRIMARY_CTRL, 32'hE000_0000, 4'h2);
    $display("test no-fill mode done");
    md(REG_CONFIG, 32'h1, 4'h4);
    acc(7'h20);
    chk("allocate", 0, dal);
    acc(7'h21);
    chk("to_memory", 1, dmem);
    acc(7'h23);
    chk("modified", 1, dmod);
    acc(7'h27);
    chk("modified", 0, dmod);
    chk("exclusive", 0, dex);
    snoop(1'b1);
    chk("l1_snoop", 0, sl1);
    chk("low_snoop", 1, slo);
    chk("snoop_inval", 0, sinv);
    chk("parity_pin", 1, perr_n);
    flush();
    chk("snoop_inval", 1, sinv);
    @(posedge clk) board <= 3'b001;
    repeat (3) @(posedge clk);
    snoop(1'b1);
    chk("l1_snoop", 1, sl1);
    chk("parity_pin", 0, perr_n);
    acc(7'h03);
    chk("write_through", 1, dwt);
    chk("cacheable", 1, dc);
    @(posedge clk) board <= 3'b011;
    repeat (3) @(posedge clk);
    acc(7'h03);
    chk("cacheable", 0, dc);
    $display("test non-coherent mode done");
    md(REG_CONFIG, 32'h2, 4'h8);
    acc(7'h03);
    chk("cacheable", 0, dc);
    rdchk(4'hF, 32'hFFFF_FFFF, 32'h0);
    $display("test low-power and unmapped done");
    wrap_up();
  end
endmodule
`default_nettype wire
